/* bench/gcrb_regbank_assertions.sv */
/* Port checker of the register bank: updates, clears, flash and sleep.
   Assumes the block's ports; bound to every instance below. */
`timescale 1ns/100ps
module gcrb_regbank_chk #(
  parameter integer FLASH_CYC = 50
) (
  // Clock and reset
  input wire ref_clk,
  input wire rstn,
  // Observed ports
  input wire spi_cs_n,
  input wire rate_vld,
  input wire rate_upd,
  input wire [2:0] op_done,
  input wire selftest_run,
  input wire memtest_run,
  input wire sense_halt,
  input wire sleeping,
  input wire flash_busy,
  input wire [11:0] dac_code_out
);
  int fcnt_r;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // A backup cut short would leave a torn flash image
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      fcnt_r <= 0;
    else
      fcnt_r <= flash_busy ? fcnt_r + 1 : 0;
  end
  AST_RATE_UPD: assert property (rate_vld && !sense_halt |=> rate_upd)
    else $error("update missing");
  AST_HALT_DROP: assert property (rate_vld && sense_halt |=> !rate_upd)
    else $error("update while halted");
  AST_SELFT_CLR: assert property ($fell(selftest_run) |-> $past(op_done[1]) || sense_halt || $past(sense_halt))
    else $error("self-test cleared early");
  AST_MEMT_HOLD: assert property (memtest_run && !op_done[2] && !sense_halt |=> memtest_run || sense_halt)
    else $error("memory test dropped");
  AST_FLASH_LEN: assert property ($fell(flash_busy) && !sense_halt |-> fcnt_r == FLASH_CYC)
    else $error("backup length wrong");
  AST_SLEEP_HALT: assert property (sleeping |-> sense_halt)
    else $error("sensing during sleep");
  AST_SLEEP_MIN: assert property ($rose(sleeping) |=> sleeping [*8])
    else $error("sleep too short");
  AST_DAC_FRAME: assert property ($changed(dac_code_out) |-> !spi_cs_n || sense_halt || $past(sense_halt))
    else $error("converter moved without command");
endmodule // gcrb_regbank_chk
bind gcrb_regbank gcrb_regbank_chk #(.FLASH_CYC(FLASH_CYC)) u_gcrb_regbank_chk (.*);

/* bench/gcrb_regbank_tb.sv */
/* Self-checking bench of the register bank with a word model of the registers.
   Assumes gcrb_spi_host as the host; counts shortened by parameters. */
`timescale 1ns/100ps
module gcrb_regbank_tb;
  reg ref_clk = 1'b0;
  reg rstn = 1'b0;
  reg [15:0] rate_in = 16'h0000;
  reg rate_vld = 1'b0;
  reg [1:0] ext = 2'h0;
  reg [1:0] alarm_claim = 2'h0;
  reg [1:0] alarm_level = 2'h0;
  reg [2:0] op_done = 3'h0;
  wire spi_cs_n, spi_sclk, spi_mosi, spi_miso, rate_upd, autonull_run, selftest_run;
  wire memtest_run, st_pos, st_neg, sense_halt, sleeping, flash_busy;
  wire [15:0] rate_out;
  wire [1:0] dio_out, dio_oe_n, dio_in;
  wire [11:0] dac_code_out;
  int miscompares = 0;
  int samples_checked = 0;
  int cyc = 0;
  int pw;
  int g [4] = '{0, 2048, 4095, 1000};
  reg [15:0] mw [0:63];
  reg [15:0] img [0:63];
  reg [15:0] r;
  bit [6:0] al [6] = '{7'h00, 7'h14, 7'h16, 7'h30, 7'h32, 7'h22};
  // Wire level of each line from both drivers
  assign dio_in = (dio_out & ~dio_oe_n) | (ext & dio_oe_n);
  gcrb_regbank #(.DRDY_CYC(20), .FLASH_CYC(50), .SLEEP_TICK_CYC(40)) u_gcrb_regbank (.*);
  gcrb_spi_host u_gcrb_spi_host (.*);
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  function automatic [15:0] msk(input [6:0] a);
    case ({a[6:1], 1'b0})
      7'h14, 7'h16, 7'h30: msk = 16'h0FFF;
      7'h32: msk = 16'h0303;
      7'h34: msk = 16'h0F07;
      7'h3A: msk = 16'h00FF;
      default: msk = 16'h0000;
    endcase
  endfunction
  function automatic [15:0] ex(input [6:0] a);
    ex = mw[a[6:1]];
    if (a[6:1] == 6'h19) ex[9:8] = (ex[9:8] & ex[1:0]) | (ext & ~ex[1:0]);
  endfunction
  task automatic report_and_stop;
    if (miscompares == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input [15:0] got, input [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input [6:0] a, input [7:0] d);
    reg [15:0] m;
    m = msk(a) & (a[0] ? 16'hFF00 : 16'h00FF);
    mw[a[6:1]] = (mw[a[6:1]] & ~m) | ({d, d} & m);
    u_gcrb_spi_host.xfer({1'b1, a, d}, r);
  endtask
  task automatic rd(input [6:0] a);
    u_gcrb_spi_host.xfer({1'b0, a, 8'h00}, r);
    u_gcrb_spi_host.xfer(16'h0000, r);
    chk(r, ex(a));
  endtask
  task automatic rate(input [15:0] v);
    int e;
    rate_in <= v;
    rate_vld <= 1'b1;
    @(posedge ref_clk);
    rate_vld <= 1'b0;
    pw = 0;
    repeat (40) begin
      @(posedge ref_clk);
      pw += (dio_out[mw[26][0]] === mw[26][1]);
    end
    e = (int'($signed(v)) + int'($signed(mw[10][11:0]))) * int'(mw[11][11:0]) >>> 11;
    chk(rate_out, e[15:0]);
  endtask
  task automatic pulse(input [2:0] d);
    op_done <= d;
    @(posedge ref_clk);
    op_done <= 3'h0;
    repeat (3) @(posedge ref_clk);
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      miscompares++;
      report_and_stop;
    end
  end
  initial begin
    void'($urandom(32'h09D1));
    for (int i = 0; i < 64; i++) mw[i] = 16'h0000;
    mw[11] = 16'h0800;
    mw[26] = 16'h0006;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    foreach (al[i]) rd(al[i]);
    rd(7'h34);
    foreach (al[i]) begin
      wr(al[i], 8'($urandom));
      wr(al[i] + 7'h01, 8'($urandom));
      rd(al[i] + 7'h01);
    end
    for (int i = 0; i < 4; i++) begin
      wr(7'h16, 8'(g[i]));
      wr(7'h17, 8'(g[i] >> 8));
      rate(16'($urandom_range(32767)) - 16'h4000);
    end
    u_gcrb_spi_host.gap = 40;
    for (int i = 4; i < 8; i++) begin
      wr(7'h34, 8'(i));
      rate(16'h0100);
      chk(16'(pw), 16'h0014);
      chk(16'(dio_oe_n[i[0]]), 16'h0000);
    end
    // Short gap again so the flash backup is still running when looked at
    u_gcrb_spi_host.gap = 4;
    wr(7'h34, 8'h06);
    wr(7'h32, 8'h03);
    wr(7'h33, 8'h03);
    chk(16'({dio_oe_n, dio_out}), 16'h0002);
    alarm_claim <= 2'h3;
    alarm_level <= 2'h1;
    repeat (3) @(posedge ref_clk);
    chk(16'(dio_out), 16'h0000);
    alarm_claim <= 2'h0;
    ext <= 2'($urandom);
    wr(7'h34, 8'h00);
    wr(7'h32, 8'h00);
    rd(7'h33);
    chk(16'(dio_oe_n), 16'h0003);
    wr(7'h30, 8'hCC);
    wr(7'h31, 8'hFC);
    chk(16'(dac_code_out), 16'h0000);
    wr(7'h3E, 8'h04);
    chk(16'(dac_code_out), 16'h0CCC);
    wr(7'h35, 8'hFF);
    chk(16'({memtest_run, selftest_run, st_neg, st_pos}), 16'h000F);
    pulse(3'h2);
    chk(16'({memtest_run, selftest_run}), 16'h0002);
    pulse(3'h4);
    mw[26][11:10] = 2'h0;
    rd(7'h35);
    wr(7'h3E, 8'h01);
    chk(16'(autonull_run), 16'h0001);
    pulse(3'h1);
    chk(16'(autonull_run), 16'h0000);
    wr(7'h3E, 8'h02);
    mw[10] = 16'h0000;
    mw[11] = 16'h0800;
    rd(7'h16);
    rate(16'h1234);
    wr(7'h14, 8'h55);
    wr(7'h3E, 8'h08);
    chk(16'(flash_busy), 16'h0001);
    repeat (200) if (flash_busy !== 1'b0) @(posedge ref_clk);
    mw[0] = mw[0] + 16'h0001;
    img = mw;
    rd(7'h00);
    wr(7'h14, 8'hAA);
    wr(7'h3E, 8'h80);
    for (int i = 10; i < 27; i++) mw[i] = img[i];
    mw[26] = mw[26] & 16'h0307;
    rd(7'h14);
    wr(7'h3A, 8'h03);
    chk(16'({sleeping, sense_halt}), 16'h0003);
    rate_in <= 16'h7FFF;
    rate_vld <= 1'b1;
    @(posedge ref_clk);
    rate_vld <= 1'b0;
    @(posedge ref_clk);
    chk(rate_out, 16'h1234);
    repeat (120) @(posedge ref_clk);
    chk(16'(sleeping), 16'h0000);
    rstn <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk(16'({dio_oe_n, dac_code_out}), 16'h2000);
    report_and_stop;
  end
endmodule // gcrb_regbank_tb

/* bench/gcrb_spi_host.sv */
/* Host SPI master model: 16-bit frames, mode 0, 160 ns serial clock.
   Assumes a 5 ns ref_clk; callers enter xfer just after a clock edge. */
`timescale 1ns/100ps
module gcrb_spi_host (
  // Clock
  input wire ref_clk,
  // Serial lines
  output reg spi_cs_n,
  output reg spi_sclk,
  output reg spi_mosi,
  input wire spi_miso
);
  int gap = 4;
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
  end
  // Serial clock stands low outside frames
  task automatic xfer(input [15:0] w, output [15:0] rd);
    spi_cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi <= w[i];
      repeat (16) @(posedge ref_clk);
      spi_sclk <= 1'b1;
      rd[i] = spi_miso;
      repeat (16) @(posedge ref_clk);
      spi_sclk <= 1'b0;
    end
    repeat (16) @(posedge ref_clk);
    spi_cs_n <= 1'b1;
    // Idle data is inverted so a stale bit never passes for a live one
    spi_mosi <= ~w[0];
    repeat (gap) @(posedge ref_clk);
  endtask
endmodule // gcrb_spi_host

/* hw/gcrb_map.vh */
/*
  Register map, field positions, reset values and timing counts of the
  rate sensor control register bank.
  Assumes a 200 MHz core clock; included by gcrb_regbank.v.
*/
`ifndef GCRB_MAP_VH
`define GCRB_MAP_VH

// Byte address of each register's low byte; high byte sits at address + 1
`define GCRB_A_FWC 7'h00
`define GCRB_A_OFF 7'h14
`define GCRB_A_GAIN 7'h16
`define GCRB_A_DAC 7'h30
`define GCRB_A_PIO 7'h32
`define GCRB_A_MISC 7'h34
`define GCRB_A_SLP 7'h3A
`define GCRB_A_CMD 7'h3E

// Reset values
`define GCRB_RST_OFF 16'h0000
`define GCRB_RST_GAIN 16'h0800
`define GCRB_RST_DAC 16'h0000
`define GCRB_RST_PIO 16'h0000
`define GCRB_RST_MISC 16'h0006

// Writable bits; GCRB_FL_MISC marks the misc bits kept in flash
`define GCRB_WM_TRIM 16'h0FFF
`define GCRB_WM_PIO 16'h0303
`define GCRB_WM_MISC 16'h0F07
`define GCRB_WM_SLP 16'h00FF
`define GCRB_WM_CMD 16'h008F
`define GCRB_FL_MISC 16'h0307

// Field positions
`define GCRB_PIO_LVL 8
`define GCRB_MISC_SEL 0
`define GCRB_MISC_POL 1
`define GCRB_MISC_EN 2
`define GCRB_MISC_STP 8
`define GCRB_MISC_STN 9
`define GCRB_MISC_SELFT 10
`define GCRB_MISC_MEMT 11
`define GCRB_CMD_NULL 0
`define GCRB_CMD_FACT 1
`define GCRB_CMD_DAC 2
`define GCRB_CMD_FLASH 3
`define GCRB_CMD_SRST 7
`define GCRB_SPI_WR 15
`define GCRB_GAIN_SHIFT 11

// Timing
`define GCRB_CLK_NS 5
`define GCRB_DRDY_MIN_US 100
`define GCRB_DRDY_CYC ((`GCRB_DRDY_MIN_US * 1000 + `GCRB_CLK_NS - 1) / `GCRB_CLK_NS)
`define GCRB_FLASH_MS 40
`define GCRB_FLASH_CYC ((`GCRB_FLASH_MS * 1000000 + `GCRB_CLK_NS - 1) / `GCRB_CLK_NS)
`define GCRB_SLEEP_TICK_MS 500
`define GCRB_SLEEP_TICK_CYC ((`GCRB_SLEEP_TICK_MS * 1000000) / `GCRB_CLK_NS)

`endif

/* hw/gcrb_regbank.v */
/*
  Control register bank of a digital rate sensor: trim of rate data, command
  triggers with flash backup and start-up reload, timed sleep, two digital
  lines, data-ready pulse, self-test and memory-test triggers, converter latch.
  Assumes a host SPI master (mode 0 or 3, sclk far below ref_clk/4) and that
  rate samples, alarm claims and operation-done pulses come from ref_clk logic.
*/
`timescale 1ns/100ps
`include "gcrb_map.vh"

// Function
// RULE1: Add signed 12-bit offset trim to rate data, 1.04 deg/s per count.
// RULE2: Multiply rate by unsigned 12-bit gain over 2048; 0x800 is unity.
// RULE3: Command bit written one starts its operation, cleared when done.
// RULE4: Bit 7 halts sensing and reloads controls from flash before new data.
// RULE5: Bit 3 flash backup, bit 1 factory restore, bit 0 autonull; bits 4 to 6 unused.
// RULE6: Sleep count puts device asleep for count times half a second.
// RULE7: Line priority: data-ready setting, then alarm, then general-purpose.
// RULE8: Pin control bits 0 and 1 set line directions, one means output.
// RULE9: Pin control bits 8 and 9 are line levels: driven or sampled.
// RULE10: Misc bit 2 enables data-ready; bit 0 picks line two when set.
// RULE11: Misc bit 1 makes data-ready active high when set.
// RULE12: One data-ready pulse per update, 100 to 200 microseconds long.
// RULE13: Misc control resets to 0x0006.
// RULE14: Misc bit 11 runs memory test, cleared on completion.
// RULE15: Misc bit 10 runs self-test, cleared on completion.
// RULE16: Misc bit 9 negative, bit 8 positive stimulus while set.
// RULE17: Command bit 2 copies the whole converter code at once.
// RULE18: Converter code is 12-bit unsigned; upper four bits unused.
// RULE19: Sixteen-bit read-only counter counts every flash update.
// RULE20: Host writes one byte per frame; low byte even address.
// RULE21: Flash backup takes 40 ms; backed-up registers restore at start-up.
// RULE22: Unused bits read zero and ignore writes.
module gcrb_regbank #(
  parameter integer DRDY_CYC = `GCRB_DRDY_CYC,
  parameter integer FLASH_CYC = `GCRB_FLASH_CYC,
  parameter integer SLEEP_TICK_CYC = `GCRB_SLEEP_TICK_CYC
) (
  // Clock and reset
  input wire ref_clk,
  input wire rstn,
  // Serial register port
  input wire spi_cs_n,
  input wire spi_sclk,
  input wire spi_mosi,
  output wire spi_miso,
  // Rate data
  input wire [15:0] rate_in,
  input wire rate_vld,
  output wire [15:0] rate_out,
  output wire rate_upd,
  // Digital lines
  input wire [1:0] dio_in,
  output wire [1:0] dio_out,
  output wire [1:0] dio_oe_n,
  // Alarm claims on the lines
  input wire [1:0] alarm_claim,
  input wire [1:0] alarm_level,
  // Converter
  output wire [11:0] dac_code_out,
  // Operations: bit 0 autonull, bit 1 self-test, bit 2 memory test
  input wire [2:0] op_done,
  output wire autonull_run,
  output wire selftest_run,
  output wire memtest_run,
  output wire st_pos,
  output wire st_neg,
  output wire sense_halt,
  output wire sleeping,
  output wire flash_busy
);

  localparam [3:0] ST_BOOT = 4'h1;
  localparam [3:0] ST_RUN = 4'h2;
  localparam [3:0] ST_FLASH = 4'h4;
  localparam [3:0] ST_SLEEP = 4'h8;

  function [15:0] merge;
    input [15:0] old;
    input [15:0] m;
    input [15:0] d;
    merge = (old & ~m) | (d & m);
  endfunction

  function [15:0] wmask;
    input [6:0] a;
    case (a)
      `GCRB_A_OFF, `GCRB_A_GAIN, `GCRB_A_DAC: wmask = `GCRB_WM_TRIM;
      `GCRB_A_PIO: wmask = `GCRB_WM_PIO;
      `GCRB_A_MISC: wmask = `GCRB_WM_MISC;
      `GCRB_A_SLP: wmask = `GCRB_WM_SLP;
      `GCRB_A_CMD: wmask = `GCRB_WM_CMD;
      default: wmask = 16'h0000;
    endcase
  endfunction

  reg [2:0] cs_s_r, sclk_s_r;
  reg [1:0] mosi_s_r, dio0_s_r, digital_line_one_s_r;
  reg [3:0] bit_cnt_r;
  reg [15:0] rx_r, fr_r, tx_r;
  reg fr_done_r, miso_r;
  reg [6:0] rd_addr_r;
  reg [15:0] off_r, gain_r, dac_r, pio_r, misc_r, fwc_r, rd_word;
  reg [7:0] slp_r, cmd_r;
  reg [11:0] dac_out_r;
  reg [15:0] fl_off_r, fl_gain_r, fl_dac_r, fl_pio_r, fl_misc_r;
  reg [3:0] st_r, st_nxt;
  reg [31:0] fl_cnt_r, tick_r, drdy_cnt_r;
  reg ld_flash, prog, restore, halt_r;
  reg [7:0] cmd_clr;
  reg [15:0] rate_out_r;
  reg rate_upd_r;
  reg [1:0] dio_out_r, dio_oe_n_r;

  wire sclk_rise = sclk_s_r[1] & ~sclk_s_r[2];
  wire sclk_fall = ~sclk_s_r[1] & sclk_s_r[2];
  wire cs_fall = ~cs_s_r[1] & cs_s_r[2];
  wire [1:0] dio_s = {digital_line_one_s_r[1], dio0_s_r[1]};

  // Decoded byte write from a finished frame
  wire wr = fr_done_r & fr_r[`GCRB_SPI_WR];
  wire [6:0] wa = {fr_r[14:9], 1'b0};
  wire [15:0] wm = (fr_r[8] ? 16'hFF00 : 16'h00FF) & wmask(wa); // RULE20 RULE22
  wire [15:0] wd = {fr_r[7:0], fr_r[7:0]};
  wire [7:0] cmd_set = (wr && wa == `GCRB_A_CMD) ? wm[7:0] & wd[7:0] : 8'h00; // RULE3 RULE5
  wire [1:0] test_set = (wr && wa == `GCRB_A_MISC) ? wm[11:10] & wd[11:10] : 2'b00;
  wire tick_end = st_r[3] && tick_r == SLEEP_TICK_CYC - 1;

  // Synchronisers; the second stage feeds logic, plus a third stage on chip select and serial clock for edge detection
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cs_s_r <= 3'h7;
      sclk_s_r <= 3'h7;
      mosi_s_r <= 2'h0;
      dio0_s_r <= 2'h0;
      digital_line_one_s_r <= 2'h0;
    end else begin
      cs_s_r <= {cs_s_r[1:0], spi_cs_n};
      sclk_s_r <= {sclk_s_r[1:0], spi_sclk};
      mosi_s_r <= {mosi_s_r[0], spi_mosi};
      dio0_s_r <= {dio0_s_r[0], dio_in[0]};
      digital_line_one_s_r <= {digital_line_one_s_r[0], dio_in[1]};
    end
  end

  // Serial frame: bit 15 write flag, bits 14:8 byte address, 7:0 data
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_r <= 4'h0;
      rx_r <= 16'h0000;
      fr_r <= 16'h0000;
      fr_done_r <= 1'b0;
      tx_r <= 16'h0000;
      miso_r <= 1'b0;
      rd_addr_r <= 7'h00;
    end else begin
      fr_done_r <= 1'b0;
      if (cs_s_r[1]) begin
        bit_cnt_r <= 4'h0;
      end else if (sclk_rise) begin
        rx_r <= {rx_r[14:0], mosi_s_r[1]};
        bit_cnt_r <= bit_cnt_r + 4'h1;
        if (bit_cnt_r == 4'hF) begin
          fr_r <= {rx_r[14:0], mosi_s_r[1]};
          fr_done_r <= 1'b1;
        end
      end
      if (fr_done_r && !fr_r[`GCRB_SPI_WR])
        rd_addr_r <= {fr_r[14:9], 1'b0};
      // Read answer goes out in the frame after the request
      if (cs_fall) begin
        tx_r <= rd_word;
        miso_r <= rd_word[15];
      end else if (sclk_fall && !cs_s_r[1] && bit_cnt_r != 4'h0) begin
        tx_r <= {tx_r[14:0], 1'b0};
        miso_r <= tx_r[14];
      end
    end
  end

  always @* begin
    case (rd_addr_r)
      `GCRB_A_FWC: rd_word = fwc_r; // RULE19
      `GCRB_A_OFF: rd_word = off_r;
      `GCRB_A_GAIN: rd_word = gain_r;
      `GCRB_A_DAC: rd_word = dac_r;
      `GCRB_A_PIO: rd_word = {6'h00, pio_r[1] ? pio_r[9] : dio_s[1], pio_r[0] ? pio_r[8] : dio_s[0],
                              6'h00, pio_r[1:0]}; // RULE9
      `GCRB_A_MISC: rd_word = misc_r;
      `GCRB_A_SLP: rd_word = {8'h00, slp_r};
      `GCRB_A_CMD: rd_word = {8'h00, cmd_r};
      default: rd_word = 16'h0000; // RULE22
    endcase
  end

  // Command sequencer
  always @* begin
    st_nxt = st_r;
    ld_flash = 1'b0;
    prog = 1'b0;
    restore = 1'b0;
    cmd_clr = {7'h00, op_done[0]};
    if (cmd_r[`GCRB_CMD_DAC])
      cmd_clr[`GCRB_CMD_DAC] = 1'b1; // RULE17
    case (st_r)
      ST_BOOT: begin
        ld_flash = 1'b1; // RULE4 RULE21
        cmd_clr = 8'hFF;
        st_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (cmd_r[`GCRB_CMD_FACT]) begin
          restore = 1'b1; // RULE5
          cmd_clr[`GCRB_CMD_FACT] = 1'b1;
        end
        if (cmd_r[`GCRB_CMD_SRST])
          st_nxt = ST_BOOT; // RULE4
        else if (cmd_r[`GCRB_CMD_FLASH])
          st_nxt = ST_FLASH;
        else if (slp_r != 8'h00)
          st_nxt = ST_SLEEP; // RULE6
      end
      ST_FLASH: begin
        if (fl_cnt_r == FLASH_CYC - 1) begin
          prog = 1'b1; // RULE21
          cmd_clr[`GCRB_CMD_FLASH] = 1'b1;
          st_nxt = ST_RUN;
        end
      end
      ST_SLEEP: begin
        if (cmd_r[`GCRB_CMD_SRST])
          st_nxt = ST_BOOT;
        else if (slp_r == 8'h00)
          st_nxt = ST_RUN;
      end
      default: st_nxt = ST_BOOT;
    endcase
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= ST_BOOT;
      halt_r <= 1'b1;
      fl_cnt_r <= 32'h0;
      tick_r <= 32'h0;
      cmd_r <= 8'h00;
      slp_r <= 8'h00;
      off_r <= `GCRB_RST_OFF;
      gain_r <= `GCRB_RST_GAIN;
      dac_r <= `GCRB_RST_DAC;
      pio_r <= `GCRB_RST_PIO;
      misc_r <= `GCRB_RST_MISC; // RULE13
      dac_out_r <= 12'h000;
      fwc_r <= 16'h0000;
      fl_off_r <= `GCRB_RST_OFF;
      fl_gain_r <= `GCRB_RST_GAIN;
      fl_dac_r <= `GCRB_RST_DAC;
      fl_pio_r <= `GCRB_RST_PIO;
      fl_misc_r <= `GCRB_RST_MISC;
    end else begin
      st_r <= st_nxt;
      halt_r <= st_nxt[0] | st_nxt[3]; // RULE4
      fl_cnt_r <= st_r[2] ? fl_cnt_r + 32'h1 : 32'h0;
      tick_r <= (st_r[3] && !tick_end) ? tick_r + 32'h1 : 32'h0;
      cmd_r <= (cmd_r & ~cmd_clr) | cmd_set; // RULE3
      if (ld_flash)
        slp_r <= 8'h00;
      else if (wr && wa == `GCRB_A_SLP)
        slp_r <= (slp_r & ~wm[7:0]) | (wd[7:0] & wm[7:0]);
      else if (tick_end)
        slp_r <= slp_r - 8'h01; // RULE6
      if (ld_flash) begin
        off_r <= fl_off_r;
        gain_r <= fl_gain_r;
        dac_r <= fl_dac_r;
        pio_r <= fl_pio_r;
        misc_r <= fl_misc_r;
      end else begin
        if (restore) begin
          off_r <= `GCRB_RST_OFF;
          gain_r <= `GCRB_RST_GAIN;
        end else if (wr && wa == `GCRB_A_OFF) begin
          off_r <= merge(off_r, wm, wd);
        end else if (wr && wa == `GCRB_A_GAIN) begin
          gain_r <= merge(gain_r, wm, wd);
        end
        if (wr && wa == `GCRB_A_DAC)
          dac_r <= merge(dac_r, wm, wd); // RULE18
        if (wr && wa == `GCRB_A_PIO)
          pio_r <= merge(pio_r, wm, wd);
        // Test bits only set from the bus; completion wins only without a new set
        misc_r[11:10] <= (misc_r[11:10] & ~op_done[2:1]) | test_set; // RULE14 RULE15
        if (wr && wa == `GCRB_A_MISC)
          misc_r[9:0] <= (misc_r[9:0] & ~wm[9:0]) | (wd[9:0] & wm[9:0]); // RULE10 RULE11 RULE16
      end
      if (cmd_r[`GCRB_CMD_DAC])
        dac_out_r <= dac_r[11:0]; // RULE17
      if (prog) begin
        fl_off_r <= off_r;
        fl_gain_r <= gain_r;
        fl_dac_r <= dac_r;
        fl_pio_r <= pio_r;
        fl_misc_r <= misc_r & `GCRB_FL_MISC;
        fwc_r <= fwc_r + 16'h0001; // RULE19
      end
    end
  end

  // Trim path; the scaled result wraps beyond 16 bits rather than saturating
  wire signed [16:0] rate_sum = $signed({rate_in[15], rate_in}) + $signed({{5{off_r[11]}}, off_r[11:0]}); // RULE1
  wire signed [29:0] rate_prod = rate_sum * $signed({1'b0, gain_r[11:0]}); // RULE2

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rate_out_r <= 16'h0000;
      rate_upd_r <= 1'b0;
      drdy_cnt_r <= 32'h0;
    end else begin
      rate_upd_r <= rate_vld & ~halt_r;
      if (rate_vld && !halt_r)
        rate_out_r <= rate_prod[15 + `GCRB_GAIN_SHIFT:`GCRB_GAIN_SHIFT];
      // Fixed width at the lower bound keeps the pulse inside the window
      if (rate_upd_r)
        drdy_cnt_r <= DRDY_CYC; // RULE12
      else if (drdy_cnt_r != 32'h0)
        drdy_cnt_r <= drdy_cnt_r - 32'h1;
    end
  end

  wire drdy_act = drdy_cnt_r != 32'h0;
  wire drdy_lvl = ~(drdy_act ^ misc_r[`GCRB_MISC_POL]); // RULE11

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_line
      wire dr_own = misc_r[`GCRB_MISC_EN] & (i == 1 ? misc_r[`GCRB_MISC_SEL] : ~misc_r[`GCRB_MISC_SEL]); // RULE10
      always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          dio_out_r[i] <= 1'b0;
          dio_oe_n_r[i] <= 1'b1;
        end else if (dr_own) begin
          dio_out_r[i] <= drdy_lvl; // RULE7
          dio_oe_n_r[i] <= 1'b0;
        end else if (alarm_claim[i]) begin
          dio_out_r[i] <= alarm_level[i]; // RULE7
          dio_oe_n_r[i] <= 1'b0;
        end else begin
          dio_out_r[i] <= pio_r[`GCRB_PIO_LVL + i]; // RULE9
          dio_oe_n_r[i] <= ~pio_r[i]; // RULE8
        end
      end
    end
  endgenerate

  assign spi_miso = miso_r;
  assign rate_out = rate_out_r;
  assign rate_upd = rate_upd_r;
  assign dio_out = dio_out_r;
  assign dio_oe_n = dio_oe_n_r;
  assign dac_code_out = dac_out_r;
  assign autonull_run = cmd_r[`GCRB_CMD_NULL];
  assign selftest_run = misc_r[`GCRB_MISC_SELFT];
  assign memtest_run = misc_r[`GCRB_MISC_MEMT];
  assign st_pos = misc_r[`GCRB_MISC_STP];
  assign st_neg = misc_r[`GCRB_MISC_STN];
  assign sense_halt = halt_r;
  assign sleeping = st_r[3];
  assign flash_busy = st_r[2];

endmodule // gcrb_regbank
